/* File: core/sps_pkg.sv */
// Shared constants for the supply set-point and fault command registers.
// Assumes a single system clock; addresses are the raw 7-bit command codes.
package sps_pkg;

    // ==================================================================
    // Command addresses (bit 7 is filled with odd parity on the wire)
    localparam logic [7:0] SPS_ADDR_CVO = 8'h0E;
    localparam logic [7:0] SPS_ADDR_CV = 8'h10;
    localparam logic [7:0] SPS_ADDR_OVA = 8'h12;
    localparam logic [7:0] SPS_ADDR_UVA = 8'h14;
    localparam logic [7:0] SPS_ADDR_CDC = 8'h16;
    localparam logic [7:0] SPS_ADDR_CC = 8'h18;
    localparam logic [7:0] SPS_ADDR_VKP = 8'h1A;
    localparam logic [7:0] SPS_ADDR_OVR = 8'h1C;
    localparam logic [7:0] SPS_ADDR_UVR = 8'h1E;
    localparam logic [7:0] SPS_ADDR_SENSE_SHORT_CONFIG = 8'h22;
    localparam logic [7:0] SPS_ADDR_UVT = 8'h24;

    // ==================================================================
    // Reset values
    localparam logic SPS_RST_CVO = 1'h0;
    localparam logic [11:0] SPS_RST_CV = 12'h1F4;
    localparam logic [7:0] SPS_RST_OVA = 8'h3E;
    localparam logic [7:0] SPS_RST_UVA = 8'h24;
    localparam logic [3:0] SPS_RST_CDC = 4'h0;
    localparam logic [7:0] SPS_RST_CC = 8'h80;
    localparam logic [7:0] SPS_RST_VKP = 8'hF0;
    localparam logic [1:0] SPS_RST_OVR = 2'h2;
    localparam logic [1:0] SPS_RST_UVR = 2'h0;
    localparam logic [3:0] SPS_RST_SENSE_SHORT_CONFIG = 4'h0;
    localparam logic [1:0] SPS_RST_UVT = 2'h3;

    // ==================================================================
    // Accepted ranges
    localparam logic [11:0] SPS_CV_MIN = 12'h12C;
    localparam logic [11:0] SPS_CV_MAX = 12'h960;
    localparam logic [11:0] SPS_OVA_MIN = 12'h03E;
    localparam logic [11:0] SPS_OVA_MAX = 12'h0FA;
    localparam logic [11:0] SPS_UVA_MIN = 12'h01E;
    localparam logic [11:0] SPS_UVA_MAX = 12'h0F0;
    localparam logic [11:0] SPS_CDC_MIN = 12'h000;
    localparam logic [11:0] SPS_CDC_MAX = 12'h00C;
    localparam logic [11:0] SPS_CC_MIN = 12'h019;
    localparam logic [11:0] SPS_CC_MAX = 12'h080;
    localparam logic [11:0] SPS_VKP_MIN = 12'h035;
    localparam logic [11:0] SPS_VKP_MAX = 12'h0F0;

    // ==================================================================
    // Field positions and decoded figures
    localparam int SPS_HI_PAR = 15;
    localparam int SPS_LO_PAR = 7;
    localparam logic [1:0] SPS_CODE_BAD = 2'h3;
    localparam logic [6:0] SPS_FREQ_C0 = 7'h32; // 50 kHz
    localparam logic [6:0] SPS_FREQ_C1 = 7'h1E; // 30 kHz
    localparam logic [6:0] SPS_FREQ_C2 = 7'h28; // 40 kHz
    localparam logic [6:0] SPS_FREQ_C3 = 7'h3C; // 60 kHz
    localparam logic [6:0] SPS_UVT_BASE_MS = 7'h08;

    typedef enum {
        sps_act_none,
        sps_act_latch,
        sps_act_restart
    } sps_action_t;

    // Address as it appears with bit 7 completing odd parity
    function automatic logic [7:0] sps_cmd_addr(input logic [7:0] a);
        return {~^a[6:0], a[6:0]};
    endfunction

endpackage

/* File: core/sps_wr_if.sv */
// Carries a command write from the register core to its parity checker.
// Assumes both ends run on the same clock; the check is combinational.
`timescale 1ns/100ps

interface sps_wr_if;
    logic [7:0] addr;
    logic [15:0] data;
    logic word;
    logic addr_ok;
    logic data_ok;

    // Register core drives the write, checker answers
    modport core (output addr, output data, output word,
                  input addr_ok, input data_ok);
    modport check (input addr, input data, input word,
                   output addr_ok, output data_ok);
endinterface

/* File: core/sps_parity_check.sv */
// Odd-parity checks for command address and word data bytes.
// Assumes the master fills all parity bits before the write reaches us.
`timescale 1ns/100ps

module sps_parity_check (
    sps_wr_if.check wr // Write under check
);
    import sps_pkg::*;

    // ==================================================================
    // Address parity: only the parity-completed form is accepted
    assign wr.addr_ok = ^wr.addr;

    // ==================================================================
    // Each data byte must hold an odd count of ones; byte writes pass
    assign wr.data_ok = !wr.word ||
        ((^wr.data[15:8]) && (^wr.data[7:0]));
endmodule // sps_parity_check

/* File: core/sps_cmd_regs.sv */
// Supply set-point and fault response command registers.
// Assumes a front end that delivers one-cycle write strobes on clock_in.
//
// Overview of operation
// - The output voltage set-point holds 300 to 2400 in bits 12:8 and 6:0, reset 500.
// - Overvoltage threshold takes 62 to 250 (reset 62), undervoltage 30 to 240 (reset 36).
// - Cable drop compensation takes 0 to 12 in bits 3:0, reset zero.
// - The current limit takes codes 25 to 128, reset 128.
// - The power knee voltage takes 53 to 240, reset 240.
// - Overvoltage response bits 1:0: 00 none, 01 latch-off, 10 restart, reset 0x02.
// - Undervoltage response bits 1:0: 00 restart, 01 latch-off, 10 none, reset 0.
// - Sense-pin short response bits 1:0: 00 none, 01 latch-off, 10 restart, reset 0.
// - Sense-pin short bits 3:2 pick 50, 30, 40 or 60 kHz detection.
// - Undervoltage timer bits 1:0 pick 8, 16, 32 or 64 ms, reset 64 ms.
// - Bit 0 of the voltage-only register disables current regulation.
// - Addresses carry odd parity in bit 7 and only that form is taken.
`timescale 1ns/100ps

module sps_cmd_regs (
    input wire logic clock_in, // System clock, 20 MHz
    input wire logic rst_n_in, // Asynchronous reset, active low
    input wire logic wr_strobe_in, // One-cycle write request
    input wire logic wr_word_in, // Request carries a 16-bit word
    input wire logic [7:0] wr_addr_in, // Parity-completed address
    input wire logic [15:0] wr_data_in, // Write data, low byte in 7:0
    output logic wr_done_out, // Write applied, one cycle
    output logic wr_error_out, // Write discarded, one cycle
    input wire logic [7:0] rd_addr_in, // Parity-completed read address
    output logic [15:0] rd_data_out, // Registered read data
    output logic rd_hit_out, // Read address is mapped
    output logic voltage_only_select_out, // Current regulation disabled
    output logic [11:0] output_voltage_setpoint_out, // 10 mV steps
    output logic [7:0] overvoltage_threshold_out, // 100 mV steps
    output logic [7:0] undervoltage_threshold_out, // 100 mV steps
    output logic [3:0] cable_drop_comp_out, // 50 mV steps
    output logic [7:0] current_limit_setpoint_out, // 0.25 mV/Rs steps
    output logic [7:0] power_knee_voltage_out, // 100 mV steps
    output sps_pkg::sps_action_t ov_action_out, // Overvoltage action
    output sps_pkg::sps_action_t uv_action_out, // Undervoltage action
    output sps_pkg::sps_action_t short_action_out, // Sense short action
    output logic [6:0] short_freq_khz_out, // Detection threshold, kHz
    output logic [6:0] uv_timer_ms_out // Undervoltage timer, ms
);
    import sps_pkg::*;

    // ==================================================================
    // Helpers

    // Saturate a written value into its accepted range
    function automatic logic [11:0] clamp(input logic [11:0] v,
                                          input logic [11:0] lo,
                                          input logic [11:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // Map a response code; the undervoltage field swaps none and restart
    function automatic sps_action_t decode_resp(input logic [1:0] c,
                                                input logic uv_map);
        case (c)
            2'h0: return uv_map ? sps_act_restart : sps_act_none;
            2'h1: return sps_act_latch;
            2'h2: return uv_map ? sps_act_none : sps_act_restart;
            default: return sps_act_none;
        endcase
    endfunction

    // Build a parity-completed word from a value of up to 12 bits
    function automatic logic [15:0] pack_word(input logic [11:0] v);
        logic [6:0] hi;
        logic [6:0] lo;
        hi = {2'h0, v[11:7]};
        lo = v[6:0];
        return {~^hi, hi, ~^lo, lo};
    endfunction

    // ==================================================================
    // Parity checker hookup
    sps_wr_if wr_chk ();

    assign wr_chk.addr = wr_addr_in;
    assign wr_chk.data = wr_data_in;
    assign wr_chk.word = wr_word_in;

    sps_parity_check u_check (
        .wr (wr_chk.check)
    );

    // ==================================================================
    // Register state
    logic cv_only_select;
    logic [11:0] cv;
    logic [7:0] overvoltage_threshold;
    logic [7:0] undervoltage_threshold;
    logic [3:0] cdc;
    logic [7:0] cc;
    logic [7:0] power_knee_voltage;
    logic [1:0] ovr;
    logic [1:0] uvr;
    logic [3:0] sense_short_config;
    logic [1:0] uvt;
    logic done;
    logic error;
    logic [15:0] rd_data;
    logic rd_hit;
    logic next_cvo;
    logic [11:0] next_cv;
    logic [7:0] next_ova;
    logic [7:0] next_uva;
    logic [3:0] next_cdc;
    logic [7:0] next_cc;
    logic [7:0] next_vkp;
    logic [1:0] next_ovr;
    logic [1:0] next_uvr;
    logic [3:0] next_sense_short_config;
    logic [1:0] next_uvt;
    logic next_done;
    logic next_error;
    logic [15:0] next_rd_data;
    logic next_rd_hit;
    logic [11:0] wval;
    logic take;

    // ==================================================================
    // Write decode; each strobe is handled at once, so spacing is the
    // master's duty and back-to-back strobes are simply both applied
    always_comb begin
        next_cvo = cv_only_select;
        next_cv = cv;
        next_ova = overvoltage_threshold;
        next_uva = undervoltage_threshold;
        next_cdc = cdc;
        next_cc = cc;
        next_vkp = power_knee_voltage;
        next_ovr = ovr;
        next_uvr = uvr;
        next_sense_short_config = sense_short_config;
        next_uvt = uvt;
        next_done = 1'b0;
        next_error = 1'b0;
        wval = {wr_data_in[12:8], wr_data_in[6:0]};
        take = wr_strobe_in && wr_chk.addr_ok;
        if (wr_strobe_in && !take) begin
            next_error = 1'b1;
        end
        if (take) begin
            next_done = 1'b1;
            case (wr_addr_in)
                sps_cmd_addr(SPS_ADDR_CVO): begin
                    if (wr_word_in) begin
                        next_error = 1'b1;
                    end else begin
                        next_cvo = wr_data_in[0];
                    end
                end
                sps_cmd_addr(SPS_ADDR_CV),
                sps_cmd_addr(SPS_ADDR_OVA),
                sps_cmd_addr(SPS_ADDR_UVA),
                sps_cmd_addr(SPS_ADDR_CC),
                sps_cmd_addr(SPS_ADDR_VKP): begin
                    // Bad parity or a byte access leaves the word as it was
                    if (!wr_word_in || !wr_chk.data_ok) begin
                        next_error = 1'b1;
                    end else if (wr_addr_in == sps_cmd_addr(SPS_ADDR_CV)) begin
                        next_cv = clamp(wval, SPS_CV_MIN,
                                        SPS_CV_MAX);
                    end else if (wr_addr_in == sps_cmd_addr(SPS_ADDR_OVA)) begin
                        next_ova = 8'(clamp(wval, SPS_OVA_MIN,
                                            SPS_OVA_MAX));
                    end else if (wr_addr_in == sps_cmd_addr(SPS_ADDR_UVA)) begin
                        next_uva = 8'(clamp(wval, SPS_UVA_MIN,
                                            SPS_UVA_MAX));
                    end else if (wr_addr_in == sps_cmd_addr(SPS_ADDR_CC)) begin
                        next_cc = 8'(clamp(wval, SPS_CC_MIN,
                                           SPS_CC_MAX));
                    end else begin
                        next_vkp = 8'(clamp(wval, SPS_VKP_MIN,
                                            SPS_VKP_MAX));
                    end
                end
                sps_cmd_addr(SPS_ADDR_CDC): begin
                    // No parity on this word; only the low nibble counts
                    if (wr_word_in) begin
                        next_cdc = 4'(clamp({8'h00, wr_data_in[3:0]},
                            SPS_CDC_MIN, SPS_CDC_MAX));
                    end else begin
                        next_error = 1'b1;
                    end
                end
                sps_cmd_addr(SPS_ADDR_OVR),
                sps_cmd_addr(SPS_ADDR_UVR): begin
                    // Code 11 has no meaning, so the field keeps its value
                    if (wr_word_in || wr_data_in[1:0] == SPS_CODE_BAD) begin
                        next_error = 1'b1;
                    end else if (wr_addr_in == sps_cmd_addr(SPS_ADDR_OVR)) begin
                        next_ovr = wr_data_in[1:0];
                    end else begin
                        next_uvr = wr_data_in[1:0];
                    end
                end
                sps_cmd_addr(SPS_ADDR_SENSE_SHORT_CONFIG): begin
                    if (wr_word_in || wr_data_in[1:0] == SPS_CODE_BAD) begin
                        next_error = 1'b1;
                    end else begin
                        next_sense_short_config = wr_data_in[3:0];
                    end
                end
                sps_cmd_addr(SPS_ADDR_UVT): begin
                    if (wr_word_in) begin
                        next_error = 1'b1;
                    end else begin
                        next_uvt = wr_data_in[1:0];
                    end
                end
                default: begin
                    next_error = 1'b1;
                end
            endcase
            if (next_error) begin
                next_done = 1'b0;
            end
        end
    end

    // ==================================================================
    // Read-back, parity bits rebuilt so the master can check them
    always_comb begin
        next_rd_hit = ^rd_addr_in;
        next_rd_data = 16'h0000;
        case (rd_addr_in)
            sps_cmd_addr(SPS_ADDR_CVO): next_rd_data = {15'h0000, cv_only_select};
            sps_cmd_addr(SPS_ADDR_CV): next_rd_data = pack_word(cv);
            sps_cmd_addr(SPS_ADDR_OVA): next_rd_data = pack_word({4'h0, overvoltage_threshold});
            sps_cmd_addr(SPS_ADDR_UVA): next_rd_data = pack_word({4'h0, undervoltage_threshold});
            sps_cmd_addr(SPS_ADDR_CDC): next_rd_data = {12'h000, cdc};
            sps_cmd_addr(SPS_ADDR_CC): next_rd_data = pack_word({4'h0, cc});
            sps_cmd_addr(SPS_ADDR_VKP): next_rd_data = pack_word({4'h0, power_knee_voltage});
            sps_cmd_addr(SPS_ADDR_OVR): next_rd_data = {14'h0000, ovr};
            sps_cmd_addr(SPS_ADDR_UVR): next_rd_data = {14'h0000, uvr};
            sps_cmd_addr(SPS_ADDR_SENSE_SHORT_CONFIG): next_rd_data = {12'h000, sense_short_config};
            sps_cmd_addr(SPS_ADDR_UVT): next_rd_data = {14'h0000, uvt};
            default: next_rd_hit = 1'b0;
        endcase
    end

    // ==================================================================
    // Register update
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cv_only_select <= SPS_RST_CVO;
            cv <= SPS_RST_CV;
            overvoltage_threshold <= SPS_RST_OVA;
            undervoltage_threshold <= SPS_RST_UVA;
            cdc <= SPS_RST_CDC;
            cc <= SPS_RST_CC;
            power_knee_voltage <= SPS_RST_VKP;
            ovr <= SPS_RST_OVR;
            uvr <= SPS_RST_UVR;
            sense_short_config <= SPS_RST_SENSE_SHORT_CONFIG;
            uvt <= SPS_RST_UVT;
            done <= 1'b0;
            error <= 1'b0;
            rd_data <= 16'h0000;
            rd_hit <= 1'b0;
        end else begin
            cv_only_select <= next_cvo;
            cv <= next_cv;
            overvoltage_threshold <= next_ova;
            undervoltage_threshold <= next_uva;
            cdc <= next_cdc;
            cc <= next_cc;
            power_knee_voltage <= next_vkp;
            ovr <= next_ovr;
            uvr <= next_uvr;
            sense_short_config <= next_sense_short_config;
            uvt <= next_uvt;
            done <= next_done;
            error <= next_error;
            rd_data <= next_rd_data;
            rd_hit <= next_rd_hit;
        end
    end

    // ==================================================================
    // Outputs; decodes are cheap, so they follow the stored codes
    assign wr_done_out = done;
    assign wr_error_out = error;
    assign rd_data_out = rd_data;
    assign rd_hit_out = rd_hit;
    assign voltage_only_select_out = cv_only_select;
    assign output_voltage_setpoint_out = cv;
    assign overvoltage_threshold_out = overvoltage_threshold;
    assign undervoltage_threshold_out = undervoltage_threshold;
    assign cable_drop_comp_out = cdc;
    assign current_limit_setpoint_out = cc;
    assign power_knee_voltage_out = power_knee_voltage;
    assign ov_action_out = decode_resp(ovr, 1'b0);
    assign uv_action_out = decode_resp(uvr, 1'b1);
    assign short_action_out = decode_resp(sense_short_config[1:0], 1'b0);
    assign uv_timer_ms_out = SPS_UVT_BASE_MS << uvt;

    // Detection threshold lookup
    always_comb begin
        case (sense_short_config[3:2])
            2'h0: short_freq_khz_out = SPS_FREQ_C0;
            2'h1: short_freq_khz_out = SPS_FREQ_C1;
            2'h2: short_freq_khz_out = SPS_FREQ_C2;
            default: short_freq_khz_out = SPS_FREQ_C3;
        endcase
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    property p_cv_range;
        cv >= SPS_CV_MIN && cv <= SPS_CV_MAX;
    endproperty
    a_cv_range: assert property (p_cv_range)
        else $error("set-point left its range");

    property p_thr_range;
        {4'h0, overvoltage_threshold} >= SPS_OVA_MIN && {4'h0, overvoltage_threshold} <= SPS_OVA_MAX &&
        {4'h0, undervoltage_threshold} >= SPS_UVA_MIN && {4'h0, undervoltage_threshold} <= SPS_UVA_MAX;
    endproperty
    a_thr_range: assert property (p_thr_range)
        else $error("threshold left its range");

    property p_cdc_range;
        cdc <= SPS_CDC_MAX[3:0];
    endproperty
    a_cdc_range: assert property (p_cdc_range)
        else $error("compensation above twelve");

    property p_cc_knee;
        {4'h0, cc} >= SPS_CC_MIN && {4'h0, cc} <= SPS_CC_MAX &&
        {4'h0, power_knee_voltage} >= SPS_VKP_MIN && {4'h0, power_knee_voltage} <= SPS_VKP_MAX;
    endproperty
    a_cc_knee: assert property (p_cc_knee)
        else $error("limit or knee left its range");

    property p_ov_write;
        wr_strobe_in && !wr_word_in && wr_data_in[1:0] == 2'h1 &&
        wr_addr_in == sps_cmd_addr(SPS_ADDR_OVR)
        |=> ov_action_out == sps_act_latch && wr_done_out;
    endproperty
    a_ov_write: assert property (p_ov_write)
        else $error("overvoltage latch-off not taken");

    property p_uv_restart;
        wr_strobe_in && !wr_word_in && wr_data_in[1:0] == 2'h0 &&
        wr_addr_in == sps_cmd_addr(SPS_ADDR_UVR)
        |=> uv_action_out == sps_act_restart;
    endproperty
    a_uv_restart: assert property (p_uv_restart)
        else $error("undervoltage code 00 is not restart");

    property p_short_freq;
        sense_short_config[3:2] == 2'h1 |-> short_freq_khz_out == SPS_FREQ_C1 &&
        short_action_out == decode_resp(sense_short_config[1:0], 1'b0);
    endproperty
    a_short_freq: assert property (p_short_freq)
        else $error("short detection decode wrong");

    property p_uv_timer;
        uv_timer_ms_out == (7'h08 << uvt) && uvt != 2'h3 |=>
        $stable(uvt) || $past(wr_strobe_in);
    endproperty
    a_uv_timer: assert property (p_uv_timer)
        else $error("timer changed without a write");

    property p_cvo_write;
        wr_strobe_in && !wr_word_in &&
        wr_addr_in == sps_cmd_addr(SPS_ADDR_CVO)
        |=> voltage_only_select_out == $past(wr_data_in[0]);
    endproperty
    a_cvo_write: assert property (p_cvo_write)
        else $error("voltage-only bit not stored");

    property p_bad_addr;
        wr_strobe_in && !(^wr_addr_in) |=> wr_error_out && $stable(cv) &&
        $stable(ovr) && $stable(uvt) && !wr_done_out;
    endproperty
    a_bad_addr: assert property (p_bad_addr)
        else $error("address without parity was taken");

    property p_bad_parity;
        wr_strobe_in && wr_word_in &&
        (!(^wr_data_in[7:0]) || !(^wr_data_in[15:8])) &&
        wr_addr_in == sps_cmd_addr(SPS_ADDR_CV) |=> $stable(cv) &&
        wr_error_out && !wr_done_out;
    endproperty
    a_bad_parity: assert property (p_bad_parity)
        else $error("word with bad parity changed register");
endmodule // sps_cmd_regs

/* File: testbench/sps_master_model.sv */
// Bus master stand-in that issues command writes to the register core.
// Assumes the core samples its write strobe on the rising clock edge.
`timescale 1ns/100ps

module sps_master_model (
    input wire logic clock_in, // System clock
    output logic wr_strobe_out, // One-cycle write request
    output logic wr_word_out, // Word or byte request
    output logic [7:0] wr_addr_out, // Parity-completed address
    output logic [15:0] wr_data_out // Write data with parity
);
    // ========
    // Idle lines; released lines toggle so no stale value looks valid
    initial begin
        wr_strobe_out = 1'b0;
        wr_word_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 16'h0000;
    end

    // One write; the bad flags break parity on purpose
    task automatic put(input logic [6:0] a, input logic [15:0] d,
            input logic w, input logic ba, input logic bd);
        logic [15:0] p;
        p = d;
        if (w) begin
            p[15] = ~^d[14:8] ^ bd;
            p[7] = ~^d[6:0];
        end
        @(posedge clock_in);
        wr_strobe_out <= 1'b1;
        wr_word_out <= w;
        wr_addr_out <= {~^a ^ ba, a};
        wr_data_out <= p;
        @(posedge clock_in);
        wr_strobe_out <= 1'b0;
        wr_addr_out <= ~wr_addr_out;
        wr_data_out <= ~wr_data_out;
    endtask
endmodule // sps_master_model

/* File: testbench/supply_setpoint_fault_command_regs_tb.sv */
// Bench: integer model of the command registers against the design.
// Assumes the master model in the same folder makes all writes.
`timescale 1ns/100ps

module supply_setpoint_fault_command_regs_tb;
    import sps_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] rd_addr_in = 8'h00;
    logic stb, wd, done, err, hit, cv_only_select;
    logic [7:0] wa, overvoltage_threshold, undervoltage_threshold, cc, power_knee_voltage;
    logic [15:0] wdat, rdat;
    logic [11:0] cv;
    logic [3:0] cdc;
    logic [6:0] fq, tm;
    sps_action_t ova_a, uva_a, sh_a;
    int n_errors = 0;
    int checks_done = 0;
    int e[7];
    int ovc, uvc, ssc, uvt, i;
    int khz[4] = '{50, 30, 40, 60};
    logic [7:0] adr[11] = '{SPS_ADDR_CVO, SPS_ADDR_CV, SPS_ADDR_OVA,
        SPS_ADDR_UVA, SPS_ADDR_CDC, SPS_ADDR_CC, SPS_ADDR_VKP,
        SPS_ADDR_OVR, SPS_ADDR_UVR, SPS_ADDR_SENSE_SHORT_CONFIG, SPS_ADDR_UVT};
    int lo[7] = '{0, 300, 62, 30, 0, 25, 53};
    int hi[7] = '{1, 2400, 250, 240, 12, 128, 240};

    always #25 clock_in = ~clock_in;

    sps_cmd_regs u_sps_cmd_regs (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .wr_strobe_in(stb), .wr_word_in(wd), .wr_addr_in(wa),
        .wr_data_in(wdat), .wr_done_out(done), .wr_error_out(err),
        .rd_addr_in(rd_addr_in), .rd_data_out(rdat), .rd_hit_out(hit),
        .voltage_only_select_out(cv_only_select), .output_voltage_setpoint_out(cv),
        .overvoltage_threshold_out(overvoltage_threshold), .undervoltage_threshold_out(undervoltage_threshold),
        .cable_drop_comp_out(cdc), .current_limit_setpoint_out(cc),
        .power_knee_voltage_out(power_knee_voltage), .ov_action_out(ova_a),
        .uv_action_out(uva_a), .short_action_out(sh_a),
        .short_freq_khz_out(fq), .uv_timer_ms_out(tm));
    sps_master_model u_sps_master_model (.clock_in(clock_in),
        .wr_strobe_out(stb), .wr_word_out(wd), .wr_addr_out(wa),
        .wr_data_out(wdat));

    // ========
    // Model and compares
    function automatic logic [15:0] pk(int v);
        logic [15:0] d;
        d = {3'h0, 5'(v >> 7), 1'b0, 7'(v)};
        return {~^d[14:8], d[14:8], ~^d[6:0], d[6:0]};
    endfunction
    function automatic sps_action_t act(int c, bit uv);
        if (c == 1) return sps_act_latch;
        return ((c == 0) ^ uv) ? sps_act_none : sps_act_restart;
    endfunction
    task automatic mreset();
        e = '{0, 500, 62, 36, 0, 128, 240};
        ovc = 2; uvc = 0; ssc = 0; uvt = 3;
    endtask
    task automatic chk_val(string n, logic [15:0] x, logic [15:0] g);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chk_act(string n, sps_action_t x, sps_action_t g);
        chk_val(n, 16'(x), 16'(g));
    endtask
    task automatic chk_regs();
        chk_val("cvo", 16'(e[0]), 16'(cv_only_select));
        chk_val("cv", 16'(e[1]), 16'(cv));
        chk_val("ova", 16'(e[2]), 16'(overvoltage_threshold));
        chk_val("uva", 16'(e[3]), 16'(undervoltage_threshold));
        chk_val("cdc", 16'(e[4]), 16'(cdc));
        chk_val("cc", 16'(e[5]), 16'(cc));
        chk_val("vkp", 16'(e[6]), 16'(power_knee_voltage));
        chk_act("ov_act", act(ovc, 0), ova_a);
        chk_act("uv_act", act(uvc, 1), uva_a);
        chk_act("sh_act", act(ssc % 4, 0), sh_a);
        chk_val("freq", 16'(khz[ssc / 4]), 16'(fq));
        chk_val("timer", 16'(8 << uvt), 16'(tm));
    endtask
    // Word index 1..6 take clamped values; byte writes store the written code, bit 0 only for index 0
    task automatic wr(int k, int v, bit ba, bit bd, bit ok);
        bit w;
        w = k >= 1 && k <= 6;
        u_sps_master_model.put(7'(adr[k]), w ? pk(v) : 16'(v), w, ba, bd);
        @(negedge clock_in);
        chk_val("done", 16'(ok), 16'(done));
        chk_val("error", 16'(!ok), 16'(err));
        if (ok && w) e[k] = v < lo[k] ? lo[k] : (v > hi[k] ? hi[k] : v);
        if (ok && k == 0) e[0] = v & 1;
        if (ok && k == 7) ovc = v;
        if (ok && k == 8) uvc = v;
        if (ok && k == 9) ssc = v;
        if (ok && k == 10) uvt = v;
    endtask
    task automatic rd(int k);
        @(posedge clock_in);
        rd_addr_in <= {~^adr[k][6:0], adr[k][6:0]};
        @(posedge clock_in);
        @(negedge clock_in);
        chk_val("rd_data", k == 4 ? 16'(e[k]) : pk(e[k]), rdat);
        chk_val("rd_hit", 16'h0001, 16'(hit));
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ========
    // Tests, then a watchdog well beyond their length
    initial begin
        void'($urandom(68375));
        mreset();
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(negedge clock_in);
        chk_regs();
        repeat (30) begin
            i = 1 + $urandom % 6;
            wr(i, $urandom % (i == 1 ? 4096 : (i == 4 ? 16 : 256)), 0, 0, 1);
            rd(i);
            chk_regs();
        end
        for (int c = 0; c < 4; c++) begin
            wr(7, c, 0, 0, c < 3);
            wr(8, c, 0, 0, c < 3);
            wr(9, c * 4 + c, 0, 0, c < 3);
            wr(10, c, 0, 0, 1);
            wr(0, c, 0, 0, 1);
            chk_regs();
        end
        wr(9, 14, 0, 0, 1);
        wr(1, 1234, 0, 1, 0);
        wr(2, 100, 1, 0, 0);
        chk_regs();
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        mreset();
        rst_n_in <= 1'b1;
        @(negedge clock_in);
        chk_regs();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clock_in);
        n_errors++;
        finish_test();
    end
endmodule // supply_setpoint_fault_command_regs_tb
